// ==== hw/alu_pkg.sv ====
package alu_pkg;
  // Operation codes, one-hot free binary select
  typedef enum logic [4:0] {
    OP_INC    = 5'h00,
    OP_DEC    = 5'h01,
    OP_COMP   = 5'h02,
    OP_COMP_A = 5'h03,
    OP_DIVB   = 5'h04,
    OP_DIVB_R = 5'h05,
    OP_DIVW   = 5'h06,
    OP_MULB   = 5'h07,
    OP_MULB_R = 5'h08,
    OP_MULW   = 5'h09,
    OP_MULW_R = 5'h0a,
    OP_AND    = 5'h0b,
    OP_OR     = 5'h0c,
    OP_XOR    = 5'h0d,
    OP_NOT    = 5'h0e,
    OP_ANDA   = 5'h0f,
    OP_ORA    = 5'h10,
    OP_XORA   = 5'h11,
    OP_NEGATE = 5'h12,
    OP_NORM   = 5'h13
  } alu_op_t;

  // Operand size
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } alu_size_t;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } alu_state_t;

  // Cycle counts
  localparam logic [5:0] CYC_INC_BYTE = 6'h02;
  localparam logic [5:0] CYC_INC_WORD = 6'h03;
  localparam logic [5:0] CYC_INC_LONG = 6'h07;
  localparam logic [5:0] CYC_COMP_BW  = 6'h02;
  localparam logic [5:0] CYC_COMP_L   = 6'h03;
  localparam logic [5:0] CYC_COMP_A   = 6'h01;
  localparam logic [5:0] CYC_DIVB_Z   = 6'h03;
  localparam logic [5:0] CYC_DIVB_V   = 6'h07;
  localparam logic [5:0] CYC_DIVB_N   = 6'h0f;
  localparam logic [5:0] CYC_DIVBR_Z  = 6'h04;
  localparam logic [5:0] CYC_DIVBR_V  = 6'h08;
  localparam logic [5:0] CYC_DIVBR_N  = 6'h10;
  localparam logic [5:0] CYC_DIVW_Z   = 6'h04;
  localparam logic [5:0] CYC_DIVW_V   = 6'h07;
  localparam logic [5:0] CYC_DIVW_N   = 6'h16;
  localparam logic [5:0] CYC_MULB_Z   = 6'h03;
  localparam logic [5:0] CYC_MULB_N   = 6'h07;
  localparam logic [5:0] CYC_MULBR_Z  = 6'h04;
  localparam logic [5:0] CYC_MULBR_N  = 6'h08;
  localparam logic [5:0] CYC_MULW_Z   = 6'h03;
  localparam logic [5:0] CYC_MULW_N   = 6'h0b;
  localparam logic [5:0] CYC_MULWR_Z  = 6'h04;
  localparam logic [5:0] CYC_MULWR_N  = 6'h0c;
  localparam logic [5:0] CYC_LOGIC_BW = 6'h02;
  localparam logic [5:0] CYC_LOGIC_L  = 6'h06;
  localparam logic [5:0] CYC_NEG      = 6'h03;
  localparam logic [5:0] CYC_NORM_Z   = 6'h04;
  localparam logic [5:0] CYC_NORM_B   = 6'h06;

  // Reset values
  localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
  localparam logic [3:0]  RST_FLAGS  = 4'h0;
  // Flag bit positions in flags vector
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_V = 1;
  localparam int FLG_C = 0;
endpackage

// ==== hw/alu_mem_if.sv ====
`timescale 1ns/1ps
interface alu_mem_if;
  logic        rd_req;
  logic        wr_req;
  logic        lock;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport core
  (
    output rd_req,
    output wr_req,
    output lock,
    output wdata,
    input  rdata
  );
  modport port
  (
    input  rd_req,
    input  wr_req,
    input  lock,
    input  wdata,
    output rdata
  );
endinterface

// ==== hw/alu_rmw_port.sv ====
`timescale 1ns/1ps
module alu_rmw_port
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Core side
  alu_mem_if.port    mi,
  input  wire logic [31:0] mem_rdata,
  // Bus side
  output logic       bus_rd,
  output logic       bus_wr,
  output logic       bus_lock,
  output logic [31:0] bus_wdata
);
  assign mi.rdata = mem_rdata;

  // bus lock spans read to write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus_rd    <= 1'b0;
      bus_wr    <= 1'b0;
      bus_lock  <= 1'b0;
      bus_wdata <= alu_pkg::RST_WORD32;
    end
    else
    begin
      bus_rd    <= mi.rd_req;
      bus_wr    <= mi.wr_req;
      bus_lock  <= mi.lock;
      bus_wdata <= mi.wdata;
    end
  end

  property p_rmw_lock;
    @(posedge clk) disable iff (rst)
    bus_wr |-> bus_lock;
  endproperty
  a_rmw_lock: assert property (p_rmw_lock)
    else $error("write outside lock");
endmodule

// ==== hw/alu_cycle_timer.sv ====
`timescale 1ns/1ps
module alu_cycle_timer
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       load,
  input  wire logic [5:0] count,
  // Status
  output logic            last
);
  logic [5:0] cnt_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 6'h00;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != 6'h00)
      cnt_q <= cnt_q - 6'h01;
  end
  assign last = (cnt_q == 6'h01);
endmodule

// ==== hw/alu_core.sv ====
`timescale 1ns/1ps
// What this block does
// - Inc/dec add or subtract one, set N Z V, keep C; long takes 7.
// - Byte register increment writes register plus one in 2 cycles.
// - Compare subtracts, stores nothing, sets NZVC; upper-lower form; imm32 3.
// - Upper half over low byte; quotient low, remainder high; V C only.
// - Accumulator byte divide: 3 zero, 7 overflow, 15 otherwise.
// - Register byte divide: 4 zero, 8 overflow, 16 otherwise.
// - Word divide: 32-bit acc by register, quotient acc, remainder reg.
// - Register word divide: 4 zero, 7 overflow, 22 otherwise.
// - Byte multiply of upper by lower half bytes, no flags, 3 or 7 cycles.
// - Byte register multiply: 4 when register zero, else 8.
// - Word acc multiply halves to 32 bits, 3 or 11 cycles.
// - Word register multiply to 32 bits, 4 or 12 cycles.
// - Byte logic sets N Z, clears V, keeps C; immediate 2 cycles.
// - Single-operand word logic combines upper half with acc in 2 cycles.
// - Long logic with register pair: 6 cycles, N Z set, V cleared.
// - Negate gives zero minus operand, NZVC; register form 3 cycles.
// - Normalize shifts left to msb one, count to byte reg, Z only.
// - Normalize: 4 cycles if zero, else 6 plus shift count.
module alu_core
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Request
  input  wire logic               start,
  input  wire alu_pkg::alu_op_t   op,
  input  wire alu_pkg::alu_size_t size,
  input  wire logic               mem_form,
  input  wire logic [31:0]        acc_in,
  input  wire logic [15:0]        acc_upper_half,
  input  wire logic [31:0]        opnd,
  input  wire logic [3:0]         flags_in,
  // Memory
  input  wire logic [31:0]        mem_rdata,
  output logic                    bus_rd,
  output logic                    bus_wr,
  output logic                    bus_lock,
  output logic [31:0]             bus_wdata,
  // Result
  output logic                    busy_q,
  output logic                    done_q,
  output logic [31:0]             acc_q,
  output logic [31:0]             reg_q,
  output logic                    acc_we_q,
  output logic                    reg_we_q,
  output logic [7:0]              shift_count_reg_q,
  output logic                    cnt_we_q,
  output logic [3:0]              flags_q
);
  alu_mem_if mi ();
  alu_pkg::alu_state_t state_q;
  logic        last;
  logic        load;
  logic [5:0]  cyc_d;
  logic [31:0] acc_d;
  logic [31:0] reg_d;
  logic        acc_we_d;
  logic        reg_we_d;
  logic        cnt_we_d;
  logic [7:0]  cnt_d;
  logic [3:0]  flags_d;
  logic        mem_q;
  logic [31:0] src;

  function automatic logic [31:0] size_mask(input alu_pkg::alu_size_t s);
    case (s)
      alu_pkg::SZ_BYTE: size_mask = 32'h0000_00ff;
      alu_pkg::SZ_WORD: size_mask = 32'h0000_ffff;
      default:          size_mask = 32'hffff_ffff;
    endcase
  endfunction

  function automatic logic msb_of(input logic [31:0] v,
                                  input alu_pkg::alu_size_t s);
    case (s)
      alu_pkg::SZ_BYTE: msb_of = v[7];
      alu_pkg::SZ_WORD: msb_of = v[15];
      default:          msb_of = v[31];
    endcase
  endfunction

  assign load = start && (state_q == alu_pkg::ST_IDLE);
  assign src  = mem_form ? mem_rdata : opnd;

  alu_cycle_timer u_timer
  (
    .clk   (clk),
    .rst   (rst),
    .load  (load),
    .count (cyc_d),
    .last  (last)
  );

  alu_rmw_port u_port
  (
    .clk       (clk),
    .rst       (rst),
    .mi        (mi),
    .mem_rdata (mem_rdata),
    .bus_rd    (bus_rd),
    .bus_wr    (bus_wr),
    .bus_lock  (bus_lock),
    .bus_wdata (bus_wdata)
  );

  // Result and cycle count, computed at start
  always_comb
  begin
    logic [31:0] m;
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] diff;
    logic [31:0] r;
    logic        ov;
    logic [15:0] q16;
    logic [31:0] q32;
    logic [5:0]  sh;
    m        = size_mask(size);
    a        = acc_in & m;
    b        = src & m;
    diff     = 33'h0_0000_0000;
    r        = 32'h0000_0000;
    ov       = 1'b0;
    q16      = 16'h0000;
    q32      = 32'h0000_0000;
    sh       = 6'h00;
    acc_d    = acc_in;
    reg_d    = src;
    acc_we_d = 1'b0;
    reg_we_d = 1'b0;
    cnt_we_d = 1'b0;
    cnt_d    = 8'h00;
    flags_d  = flags_in;
    cyc_d    = alu_pkg::CYC_LOGIC_BW;
    case (op)
      // plus or minus one, carry kept
      alu_pkg::OP_INC, alu_pkg::OP_DEC:
      begin
        if (op == alu_pkg::OP_INC)
          r = (b + 32'h0000_0001) & m;
        else
          r = (b - 32'h0000_0001) & m;
        ov = (op == alu_pkg::OP_INC) ? (r == ((m >> 1) + 32'h0000_0001))
                                     : (r == (m >> 1));
        reg_d    = r;
        reg_we_d = 1'b1;
        flags_d[alu_pkg::FLG_N] = msb_of(r, size);
        flags_d[alu_pkg::FLG_Z] = (r == 32'h0000_0000);
        flags_d[alu_pkg::FLG_V] = ov;
        case (size)
          alu_pkg::SZ_BYTE: cyc_d = (op == alu_pkg::OP_INC)
                                    ? alu_pkg::CYC_INC_BYTE
                                    : alu_pkg::CYC_INC_WORD;
          alu_pkg::SZ_WORD: cyc_d = alu_pkg::CYC_INC_WORD;
          default:          cyc_d = alu_pkg::CYC_INC_LONG;
        endcase
      end
      alu_pkg::OP_COMP, alu_pkg::OP_COMP_A:
      begin
        if (op == alu_pkg::OP_COMP_A)
        begin
          a = {16'h0000, acc_upper_half} & m;
          b = acc_in & m;
        end
        diff = {1'b0, a} - {1'b0, b};
        r    = diff[31:0] & m;
        flags_d[alu_pkg::FLG_N] = msb_of(r, size);
        flags_d[alu_pkg::FLG_Z] = (r == 32'h0000_0000);
        flags_d[alu_pkg::FLG_V] = (msb_of(a, size) != msb_of(b, size)) &&
                                  (msb_of(r, size) != msb_of(a, size));
        flags_d[alu_pkg::FLG_C] = (a < b);
        if (op == alu_pkg::OP_COMP_A)
          cyc_d = alu_pkg::CYC_COMP_A;
        else if (size == alu_pkg::SZ_LONG)
          cyc_d = alu_pkg::CYC_COMP_L;
        else
          cyc_d = alu_pkg::CYC_COMP_BW;
      end
      alu_pkg::OP_DIVB, alu_pkg::OP_DIVB_R:
      begin
        b  = (op == alu_pkg::OP_DIVB) ? {24'h00_0000, acc_in[7:0]}
                                      : {24'h00_0000, src[7:0]};
        a  = (op == alu_pkg::OP_DIVB) ? {16'h0000, acc_upper_half}
                                      : {16'h0000, acc_in[15:0]};
        ov = (b == 32'h0000_0000) || ((a >> 8) >= b);
        flags_d[alu_pkg::FLG_V] = ov;
        flags_d[alu_pkg::FLG_C] = ov;
        if (!ov)
        begin
          q16 = a[15:0] / b[15:0];
          r   = a % b;
          acc_we_d = 1'b1;
          if (op == alu_pkg::OP_DIVB)
            // Remainder lands in the upper half
            acc_d = {acc_upper_half[15:8], r[7:0], acc_in[15:8],
                     q16[7:0]};
          else
          begin
            acc_d    = {acc_in[31:8], q16[7:0]};
            reg_d    = {src[31:8], r[7:0]};
            reg_we_d = 1'b1;
          end
        end
        if (op == alu_pkg::OP_DIVB)
          cyc_d = ov ? alu_pkg::CYC_DIVB_V :
                  (q16 == 16'h0000) ? alu_pkg::CYC_DIVB_Z
                                    : alu_pkg::CYC_DIVB_N;
        else
          cyc_d = ov ? alu_pkg::CYC_DIVBR_V :
                  (q16 == 16'h0000) ? alu_pkg::CYC_DIVBR_Z
                                    : alu_pkg::CYC_DIVBR_N;
      end
      alu_pkg::OP_DIVW:
      begin
        b  = {16'h0000, src[15:0]};
        ov = (b == 32'h0000_0000) || ((acc_in >> 16) >= b);
        flags_d[alu_pkg::FLG_V] = ov;
        flags_d[alu_pkg::FLG_C] = ov;
        if (!ov)
        begin
          q32      = acc_in / b;
          r        = acc_in % b;
          acc_d    = {acc_in[31:16], q32[15:0]};
          reg_d    = {16'h0000, r[15:0]};
          acc_we_d = 1'b1;
          reg_we_d = 1'b1;
        end
        cyc_d = ov ? alu_pkg::CYC_DIVW_V :
                (q32 == 32'h0000_0000) ? alu_pkg::CYC_DIVW_Z
                                       : alu_pkg::CYC_DIVW_N;
      end
      alu_pkg::OP_MULB, alu_pkg::OP_MULB_R:
      begin
        a = (op == alu_pkg::OP_MULB) ? {24'h00_0000, acc_upper_half[7:0]}
                                     : {24'h00_0000, src[7:0]};
        // Sized so the product keeps all 16 bits
        r = {16'h0000, 16'(a[7:0]) * 16'(acc_in[7:0])};
        acc_d    = {acc_in[31:16], r[15:0]};
        acc_we_d = 1'b1;
        if (op == alu_pkg::OP_MULB)
          cyc_d = (a == 32'h0000_0000) ? alu_pkg::CYC_MULB_Z
                                       : alu_pkg::CYC_MULB_N;
        else
          cyc_d = (a == 32'h0000_0000) ? alu_pkg::CYC_MULBR_Z
                                       : alu_pkg::CYC_MULBR_N;
      end
      alu_pkg::OP_MULW, alu_pkg::OP_MULW_R:
      begin
        a = (op == alu_pkg::OP_MULW) ? {16'h0000, acc_upper_half}
                                     : {16'h0000, src[15:0]};
        acc_d    = a[15:0] * acc_in[15:0];
        acc_we_d = 1'b1;
        if (op == alu_pkg::OP_MULW)
          cyc_d = (a == 32'h0000_0000) ? alu_pkg::CYC_MULW_Z
                                       : alu_pkg::CYC_MULW_N;
        else
          cyc_d = (a == 32'h0000_0000) ? alu_pkg::CYC_MULWR_Z
                                       : alu_pkg::CYC_MULWR_N;
      end
      // logic ops, N Z, V cleared
      alu_pkg::OP_AND, alu_pkg::OP_OR, alu_pkg::OP_XOR, alu_pkg::OP_NOT:
      begin
        case (op)
          alu_pkg::OP_AND: r = a & b;
          alu_pkg::OP_OR:  r = a | b;
          alu_pkg::OP_XOR: r = a ^ b;
          default:         r = ~a & m;
        endcase
        acc_d    = (acc_in & ~m) | r;
        acc_we_d = 1'b1;
        flags_d[alu_pkg::FLG_N] = msb_of(r, size);
        flags_d[alu_pkg::FLG_Z] = (r == 32'h0000_0000);
        flags_d[alu_pkg::FLG_V] = 1'b0;
        cyc_d = (size == alu_pkg::SZ_LONG) ? alu_pkg::CYC_LOGIC_L
                                           : alu_pkg::CYC_LOGIC_BW;
      end
      alu_pkg::OP_ANDA, alu_pkg::OP_ORA, alu_pkg::OP_XORA:
      begin
        case (op)
          alu_pkg::OP_ANDA: q16 = acc_upper_half & acc_in[15:0];
          alu_pkg::OP_ORA:  q16 = acc_upper_half | acc_in[15:0];
          default:          q16 = acc_upper_half ^ acc_in[15:0];
        endcase
        acc_d    = {acc_in[31:16], q16};
        acc_we_d = 1'b1;
        flags_d[alu_pkg::FLG_N] = q16[15];
        flags_d[alu_pkg::FLG_Z] = (q16 == 16'h0000);
        flags_d[alu_pkg::FLG_V] = 1'b0;
        cyc_d = alu_pkg::CYC_LOGIC_BW;
      end
      alu_pkg::OP_NEGATE:
      begin
        r        = (32'h0000_0000 - b) & m;
        reg_d    = r;
        reg_we_d = 1'b1;
        flags_d[alu_pkg::FLG_N] = msb_of(r, size);
        flags_d[alu_pkg::FLG_Z] = (r == 32'h0000_0000);
        flags_d[alu_pkg::FLG_V] = (r == ((m >> 1) + 32'h0000_0001));
        flags_d[alu_pkg::FLG_C] = (b != 32'h0000_0000);
        cyc_d = alu_pkg::CYC_NEG;
      end
      alu_pkg::OP_NORM:
      begin
        for (int i = 31; i >= 0; i--)
          if (acc_in[i] && (sh == 6'h00) && (r == 32'h0000_0000))
          begin
            sh = 6'(31 - i);
            r  = 32'h0000_0001;
          end
        acc_d    = acc_in << sh;
        acc_we_d = 1'b1;
        cnt_d    = {2'b00, sh};
        cnt_we_d = 1'b1;
        flags_d[alu_pkg::FLG_Z] = (acc_in == 32'h0000_0000);
        cyc_d = (acc_in == 32'h0000_0000) ? alu_pkg::CYC_NORM_Z
                                          : 6'(alu_pkg::CYC_NORM_B + sh);
      end
      default:
        cyc_d = alu_pkg::CYC_LOGIC_BW;
    endcase
  end

  // Engine sequencing
  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= alu_pkg::ST_IDLE;
    else
      case (state_q)
        alu_pkg::ST_IDLE: if (start) state_q <= alu_pkg::ST_BUSY;
        alu_pkg::ST_BUSY: if (last)  state_q <= alu_pkg::ST_DONE;
        alu_pkg::ST_DONE: state_q <= alu_pkg::ST_IDLE;
        default:          state_q <= alu_pkg::ST_IDLE;
      endcase
  end

  // Results latched at start, held until the next start
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q             <= alu_pkg::RST_WORD32;
      reg_q             <= alu_pkg::RST_WORD32;
      acc_we_q          <= 1'b0;
      reg_we_q          <= 1'b0;
      cnt_we_q          <= 1'b0;
      shift_count_reg_q <= 8'h00;
      flags_q           <= alu_pkg::RST_FLAGS;
      mem_q             <= 1'b0;
    end
    else if (load)
    begin
      acc_q             <= acc_d;
      reg_q             <= reg_d;
      acc_we_q          <= acc_we_d;
      reg_we_q          <= reg_we_d & ~mem_form;
      cnt_we_q          <= cnt_we_d;
      shift_count_reg_q <= cnt_d;
      flags_q           <= flags_d;
      mem_q             <= mem_form & reg_we_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      // No busy blip in the done-to-idle cycle
      busy_q <= load || ((state_q == alu_pkg::ST_BUSY) && !last);
      done_q <= (state_q == alu_pkg::ST_BUSY) && last;
    end
  end

  assign mi.rd_req = load && mem_form;
  assign mi.lock   = (load && mem_form) ||
                     (mem_q && (state_q == alu_pkg::ST_BUSY));
  assign mi.wr_req = mem_q && (state_q == alu_pkg::ST_BUSY) && last;
  assign mi.wdata  = reg_q;

  property p_inc_long;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_INC && size == alu_pkg::SZ_LONG)
      |-> !done_q [*8] ##1 done_q;
  endproperty
  a_inc_long: assert property (p_inc_long)
    else $error("long inc timing");

  property p_inc_byte;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_INC && size == alu_pkg::SZ_BYTE)
      |-> ##3 done_q;
  endproperty
  a_inc_byte: assert property (p_inc_byte)
    else $error("byte inc timing");

  property p_comp_nostore;
    @(posedge clk) disable iff (rst)
    (load && (op == alu_pkg::OP_COMP || op == alu_pkg::OP_COMP_A))
      |=> !acc_we_q && !reg_we_q;
  endproperty
  a_comp_nostore: assert property (p_comp_nostore)
    else $error("compare wrote result");

  // accumulator divide is 3, 7 or 15
  property p_divb_time;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_DIVB)
      |-> ##4 done_q or ##8 done_q or ##16 done_q;
  endproperty
  a_divb_time: assert property (p_divb_time)
    else $error("byte divide timing");

  // word divide is 4, 7 or 22
  property p_divw_time;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_DIVW)
      |-> ##5 done_q or ##8 done_q or ##23 done_q;
  endproperty
  a_divw_time: assert property (p_divw_time)
    else $error("word divide timing");

  property p_mul_flags;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_MULB) |=> flags_q == $past(flags_in);
  endproperty
  a_mul_flags: assert property (p_mul_flags)
    else $error("multiply changed flags");

  property p_logic_v;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_AND)
      |=> !flags_q[alu_pkg::FLG_V] &&
          flags_q[alu_pkg::FLG_C] == $past(flags_in[alu_pkg::FLG_C]);
  endproperty
  a_logic_v: assert property (p_logic_v)
    else $error("logic flag error");

  property p_norm_zero;
    @(posedge clk) disable iff (rst)
    (load && op == alu_pkg::OP_NORM && acc_in == 32'h0000_0000)
      |-> ##5 done_q;
  endproperty
  a_norm_zero: assert property (p_norm_zero)
    else $error("normalize zero timing");
endmodule

// ==== verif/cpu_arith_logic_unit_test.sv ====
`timescale 1ns/1ps
module cpu_arith_logic_unit_test;
  // Operation select
  alu_pkg::alu_op_t   op = alu_pkg::OP_INC;
  alu_pkg::alu_size_t size = alu_pkg::SZ_BYTE;
  alu_pkg::alu_op_t   lop [7] = '{alu_pkg::OP_AND, alu_pkg::OP_OR,
    alu_pkg::OP_XOR, alu_pkg::OP_NOT, alu_pkg::OP_ANDA, alu_pkg::OP_ORA,
    alu_pkg::OP_XORA};
  alu_pkg::alu_op_t   lmul [4] = '{alu_pkg::OP_MULB, alu_pkg::OP_MULB_R,
    alu_pkg::OP_MULW, alu_pkg::OP_MULW_R};
  // Stimulus
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        mem_form = 1'b0;
  logic [31:0] acc_in = 32'h0000_0000;
  logic [15:0] acc_upper_half = 16'h0000;
  logic [31:0] opnd = 32'h0000_0000;
  logic [3:0]  flags_in = 4'h0;
  logic [31:0] mem_rdata = 32'h0000_0000;
  // Design outputs
  logic        bus_rd, bus_wr, bus_lock, busy_q, done_q;
  logic        acc_we_q, reg_we_q, cnt_we_q;
  logic [31:0] bus_wdata, acc_q, reg_q;
  logic [7:0]  shift_count_reg_q;
  logic [3:0]  flags_q;
  // Bench state
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          seed = 76248;
  int          cyc = 0;
  int          ncyc, j;
  int          dcy [9] = '{3, 7, 15, 4, 8, 16, 4, 7, 22};
  logic [31:0] dvn [9] = '{2, 9, 'h100, 2, 9, 'h100, 2, 9, 'h186a0};
  logic [31:0] dvs [9] = '{5, 0, 3, 5, 0, 3, 5, 0, 7};
  logic [31:0] lres [7] = '{'h18, 'hfc, 'he4, 'h87, 'h5600, 'hff78, 'ha978};
  logic        mf = 1'b0;
  logic        rd_ok, lock_ok;
  logic [31:0] a, b, p, m;
  logic [15:0] h, u, v;
  logic [3:0]  f;

  alu_core i_dut
  (
    .clk, .rst, .start, .op, .size, .mem_form, .acc_in, .acc_upper_half,
    .opnd, .flags_in, .mem_rdata, .bus_rd, .bus_wr, .bus_lock, .bus_wdata,
    .busy_q, .done_q, .acc_q, .reg_q, .acc_we_q, .reg_we_q,
    .shift_count_reg_q, .cnt_we_q, .flags_q
  );

  always #12.5 clk = ~clk;

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: result %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flg(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: flags %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic check_cyc(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: cycles %0d, expected %0d", $time, got,
               exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Operand also on mem_rdata, valid on the taking edge for memory forms
  task automatic run(input alu_pkg::alu_op_t o, input alu_pkg::alu_size_t s,
                     input logic [31:0] x, input logic [15:0] y,
                     input logic [31:0] z, input logic [3:0] g);
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    size <= s;
    mem_form <= mf;
    acc_in <= x;
    acc_upper_half <= y;
    opnd <= z;
    mem_rdata <= z;
    flags_in <= g;
    @(posedge clk);
    start <= 1'b0;
    #1;
    rd_ok = bus_rd;
    ncyc = 0;
    lock_ok = 1'b1;
    do
    begin
      @(posedge clk);
      #1;
      ncyc++;
      lock_ok = lock_ok & bus_lock;
    end
    while (done_q !== 1'b1 && ncyc < 60);
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    run(alu_pkg::OP_INC, alu_pkg::SZ_BYTE, 0, 0, 32'h7f, 4'h1);
    check_cyc(ncyc, 2);
    check_val(reg_q & 32'hff, 32'h80);
    check_flg(flags_q, 4'hb);
    run(alu_pkg::OP_DEC, alu_pkg::SZ_BYTE, 0, 0, 0, 4'h0);
    check_val(reg_q & 32'hff, 32'hff);
    check_flg(flags_q, 4'h8);
    run(alu_pkg::OP_INC, alu_pkg::SZ_LONG, 0, 0, 32'hffff_ffff, 4'h1);
    check_cyc(ncyc, 7);
    check_flg(flags_q, 4'h5);
    run(alu_pkg::OP_COMP, alu_pkg::SZ_BYTE, 32'h10, 0, 32'h20, 4'h0);
    check_flg(flags_q, 4'h9);
    check_flg({3'h0, acc_we_q}, 4'h0);
    run(alu_pkg::OP_COMP, alu_pkg::SZ_LONG, 32'h1234_5678, 0, 32'h1234_5678,
        4'h9);
    check_cyc(ncyc, 3);
    check_flg(flags_q, 4'h4);
    run(alu_pkg::OP_COMP_A, alu_pkg::SZ_BYTE, 32'h05, 16'h0005, 0, 4'h0);
    check_flg(flags_q, 4'h4);
    for (j = 0; j < 7; j++)
    begin
      run(lop[j], j < 4 ? alu_pkg::SZ_BYTE : alu_pkg::SZ_WORD, 32'h5678,
          16'hff00, 32'h9c, 4'h3);
      check_cyc(ncyc, 2);
      check_val(acc_q & (j < 4 ? 32'hff : 32'hffff), lres[j]);
      if (j < 4)
        check_flg(flags_q, {lres[j][7], 3'b001});
    end
    run(alu_pkg::OP_AND, alu_pkg::SZ_LONG, 32'h8000_00ff, 0, 32'hf000_000f,
        4'h2);
    check_cyc(ncyc, 6);
    check_val(acc_q, 32'h8000_000f);
    check_flg(flags_q, 4'h8);
    run(alu_pkg::OP_NEGATE, alu_pkg::SZ_BYTE, 0, 0, 32'h80, 4'h0);
    check_cyc(ncyc, 3);
    check_val(reg_q & 32'hff, 32'h80);
    check_flg(flags_q, 4'hb);
    run(alu_pkg::OP_NORM, alu_pkg::SZ_LONG, 32'h0000_1000, 0, 0, 4'hf);
    check_cyc(ncyc, 25);
    check_val(acc_q, 32'h8000_0000);
    check_val({23'h0, cnt_we_q, shift_count_reg_q}, 32'h0000_0113);
    check_flg(flags_q, 4'hb);
    run(alu_pkg::OP_NORM, alu_pkg::SZ_LONG, 32'h8000_0001, 0, 0, 4'h4);
    check_cyc(ncyc, 6);
    check_flg(flags_q, 4'h0);
    run(alu_pkg::OP_NORM, alu_pkg::SZ_LONG, 0, 0, 0, 4'h0);
    check_cyc(ncyc, 4);
    check_flg(flags_q, 4'h4);
    // Zero result, divide by zero, then a normal case for each form
    for (j = 0; j < 9; j++)
    begin
      if (j < 3)
        run(alu_pkg::OP_DIVB, alu_pkg::SZ_BYTE, dvs[j], dvn[j][15:0], 0,
            4'hc);
      else
        run(j < 6 ? alu_pkg::OP_DIVB_R : alu_pkg::OP_DIVW,
            j < 6 ? alu_pkg::SZ_BYTE : alu_pkg::SZ_WORD, dvn[j], 0, dvs[j],
            4'hc);
      check_cyc(ncyc, dcy[j]);
      m = j < 6 ? 32'hff : 32'hffff;
      if (dvs[j] == 0)
        check_flg({3'h0, acc_we_q}, 4'h0);
      else
        check_val(acc_q & m, dvn[j] / dvs[j]);
      if (j < 3 && dvs[j] != 0)
        check_val((acc_q >> 16) & 32'hff, dvn[j] % dvs[j]);
      check_flg(flags_q, dvs[j] == 0 ? 4'hf : 4'hc);
    end
    check_val(reg_q & 32'hffff, 32'd5);
    // Last quarter forces zero operands to reach the short paths
    for (j = 0; j < 16; j++)
    begin
      a = $random(seed);
      b = $random(seed);
      h = $random(seed);
      f = $random(seed);
      if (j > 11)
      begin
        h = 16'h0000;
        b = 32'h0000_0000;
      end
      u = j[0] ? b[15:0] : h;
      v = a[15:0];
      if (j % 4 < 2)
      begin
        u = u & 16'h00ff;
        v = v & 16'h00ff;
      end
      p = u * v;
      run(lmul[j % 4], j % 4 < 2 ? alu_pkg::SZ_BYTE : alu_pkg::SZ_WORD, a, h,
          b, f);
      m = (j[0] ? 4 : 3) + (u == 0 ? 0 : (j % 4 < 2 ? 4 : 8));
      check_cyc(ncyc, m);
      m = j % 4 < 2 ? 32'hffff : 32'hffff_ffff;
      check_val(acc_q & m, p);
      check_flg(flags_q, f);
    end
    mf = 1'b1;
    run(alu_pkg::OP_INC, alu_pkg::SZ_BYTE, 0, 0, 32'h41, 4'h0);
    mf = 1'b0;
    check_flg({2'h0, rd_ok, lock_ok}, 4'h3);
    // Write-back shows with done, lock still held
    check_flg({bus_wr, bus_lock, busy_q, reg_we_q}, 4'hc);
    check_val(bus_wdata & 32'hff, 32'h42);
    @(posedge clk);
    #1;
    check_flg({bus_wr, bus_lock, busy_q, bus_rd}, 4'h0);
    finish_test();
  end
endmodule
